// ### logic/ptc_counter.sv
// one 16-bit programmable interval counter with byte-wide host access
`timescale 1ns/1ps
`default_nettype none
module ptc_counter
    import ptc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // host access strobes
    input  wire logic       ctl_wr,
    input  wire logic       data_wr,
    input  wire logic       data_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    // counting
    input  wire logic       tick,
    input  wire logic       gate,
    output logic            out,
    output logic            tc
);

    ptc_mode_t        mode;
    ptc_rw_t          rw;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] latch_val;
    logic             latched;
    logic             wr_hi;
    logic             rd_hi;
    logic             pending;
    logic             running;
    logic             gate_prev;
    logic             trig;
    logic             hw_mode;
    logic             trig_take;
    logic             is_latch;
    logic [CNT_W-1:0] src;

    assign hw_mode   = (mode == PTC_MODE1) || (mode == PTC_MODE5);
    assign is_latch  = (wdata[CTL_RW_MSB:CTL_RW_LSB] == 2'h0);
    assign trig_take = tick && hw_mode && trig && !ctl_wr && !data_wr;

    // gate rising edge arms the hardware-triggered modes; a new edge wins over consumption
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_prev <= 1'b0;
            trig      <= 1'b0;
        end else begin
            gate_prev <= gate;
            if (gate && !gate_prev) begin
                trig <= 1'b1;
            end else if (trig_take || (ctl_wr && !is_latch)) begin
                trig <= 1'b0;
            end
        end
    end

    // programming, loading and counting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode    <= PTC_MODE0;
            rw      <= PTC_RW_LSB;
            count   <= RST_COUNT;
            reload  <= RST_COUNT;
            wr_hi   <= 1'b0;
            pending <= 1'b0;
            running <= 1'b0;
            out     <= 1'b0;
            tc      <= 1'b0;
        end else begin
            tc <= 1'b0;
            if (ctl_wr && !is_latch) begin
                mode    <= ptc_decode_mode(wdata[CTL_MODE_MSB:CTL_MODE_LSB]);
                rw      <= ptc_rw_t'(wdata[CTL_RW_MSB:CTL_RW_LSB]);
                wr_hi   <= 1'b0;
                pending <= 1'b0;
                running <= 1'b0;
                out     <= (ptc_decode_mode(wdata[CTL_MODE_MSB:CTL_MODE_LSB]) != PTC_MODE0);
            end else if (data_wr) begin
                case (rw)
                    PTC_RW_LSB: begin
                        reload  <= {8'h00, wdata};
                        pending <= 1'b1;
                    end
                    PTC_RW_MSB: begin
                        reload  <= {wdata, 8'h00};
                        pending <= 1'b1;
                    end
                    PTC_RW_BOTH: begin
                        if (!wr_hi) begin
                            reload[7:0] <= wdata;
                            wr_hi       <= 1'b1;
                            // a half-written count is not loaded by a plain tick, though a gate trigger in modes 1 and 5 still loads it
                            pending     <= 1'b0;
                            if (mode == PTC_MODE0) begin
                                running <= 1'b0;
                                out     <= 1'b0;
                            end
                        end else begin
                            reload[15:8] <= wdata;
                            wr_hi        <= 1'b0;
                            pending      <= 1'b1;
                        end
                    end
                    default: begin
                        pending <= pending;
                    end
                endcase
            end else if (tick) begin
                if (pending && !hw_mode) begin
                    count   <= reload;
                    pending <= 1'b0;
                    running <= 1'b1;
                end else if (trig_take) begin
                    count   <= reload;
                    pending <= 1'b0;
                    running <= 1'b1;
                    out     <= (mode != PTC_MODE1);
                end else if (running && (gate || hw_mode)) begin
                    case (mode)
                        PTC_MODE2: begin
                            if (count == 16'h0001) begin
                                count <= reload;
                                out   <= 1'b1;
                            end else begin
                                count <= count - 16'h0001;
                                out   <= (count != 16'h0002);
                            end
                        end
                        PTC_MODE3: begin
                            // half period of reload/2 ticks, toggling at each reload
                            if ((count == 16'h0002) || (count == 16'h0001)) begin
                                count <= reload;
                                out   <= ~out;
                            end else begin
                                count <= count - 16'h0002;
                            end
                        end
                        default: begin
                            count <= count - 16'h0001;
                            if (count == 16'h0001) begin
                                tc  <= 1'b1;
                                out <= (mode == PTC_MODE0) || (mode == PTC_MODE1);
                                if (!((mode == PTC_MODE0) || (mode == PTC_MODE1))) begin
                                    running <= 1'b0;
                                end
                            end
                        end
                    endcase
                end else if (((mode == PTC_MODE4) || (mode == PTC_MODE5)) && !out) begin
                    // strobe lasts a single count tick
                    out <= 1'b1;
                end
            end
        end
    end

    // read path: latch command freezes the count until it is read, both bytes in two-byte mode and one byte otherwise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_val <= RST_COUNT;
            latched   <= 1'b0;
            rd_hi     <= 1'b0;
        end else if (ctl_wr) begin
            if (is_latch) begin
                if (!latched) begin
                    latch_val <= count;
                    latched   <= 1'b1;
                end
            end else begin
                latched <= 1'b0;
                rd_hi   <= 1'b0;
            end
        end else if (data_rd) begin
            if (rw == PTC_RW_BOTH) begin
                rd_hi <= ~rd_hi;
                if (rd_hi) begin
                    latched <= 1'b0;
                end
            end else begin
                latched <= 1'b0;
            end
        end
    end

    assign src   = latched ? latch_val : count;
    assign rdata = ((rw == PTC_RW_MSB) || ((rw == PTC_RW_BOTH) && rd_hi)) ? src[15:8] : src[7:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_mode0_start_low;
        (ctl_wr && !is_latch && (wdata[CTL_MODE_MSB:CTL_MODE_LSB] == 3'h0)) |=> !out;
    endproperty
    a_mode0_start_low: assert property (p_mode0_start_low) else $error("mode 0 output not low after programming");

    property p_mode0_terminal;
        (tc && (mode == PTC_MODE0)) |-> out ##1 (out || ctl_wr || data_wr || $past(ctl_wr || data_wr));
    endproperty
    a_mode0_terminal: assert property (p_mode0_terminal) else $error("mode 0 output not high at zero");

    property p_both_byte_order;
        (data_wr && !ctl_wr && (rw == PTC_RW_BOTH) && !wr_hi) |=> (wr_hi && !pending);
    endproperty
    a_both_byte_order: assert property (p_both_byte_order) else $error("low byte did not precede high byte");

    property p_count_on_tick;
        (tick && running && gate && !pending && (mode == PTC_MODE0) && !ctl_wr && !data_wr)
            |=> (count == 16'($past(count) - 16'h0001));
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) else $error("event not counted");

endmodule : ptc_counter
`default_nettype wire

// ### logic/ptc_pkg.sv
// constants, types and helpers for the pacer and pre-trigger counter block
// Behaviour
// - Three independent counters, each programmable into one of six modes.
// - Counters 1 and 2 are chained to make the periodic A/D pacer trigger.
// - Pacer runs from a 2 MHz base clock, fastest output one quarter of it.
// - Slowest pacer rate is base clock over the largest divisor of both stages.
// - Pacer output is a selectable interrupt source and selectable A/D trigger source.
// - Counter 0 counts the selected A/D trigger events.
// - Pre-trigger falling edge sets counter 0 gate; counter 0 reaching zero clears it.
// - Four I/O locations: counter data at 0x40, 0x42, 0x44, control at 0x46.
// - Counter data ports move one byte per access; full counts use successive bytes.
// - Post-trigger sample count is programmable up to 65535.
// - Second interrupt request selects pacer output or external interrupt input.
package ptc_pkg;

    localparam logic [7:0] OFS_PRETRIG  = 8'h40;
    localparam logic [7:0] OFS_STAGE1   = 8'h42;
    localparam logic [7:0] OFS_STAGE2   = 8'h44;
    localparam logic [7:0] OFS_CONTROL  = 8'h46;

    // control byte fields
    localparam int CTL_SEL_MSB  = 7;
    localparam int CTL_SEL_LSB  = 6;
    localparam int CTL_RW_MSB   = 5;
    localparam int CTL_RW_LSB   = 4;
    localparam int CTL_MODE_MSB = 3;
    localparam int CTL_MODE_LSB = 1;

    localparam int CNT_W = 16;

    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
    localparam logic [7:0]       RST_BYTE  = 8'h00;

    localparam int CLK_HZ   = 10_000_000;
    localparam int BASE_HZ  = 2_000_000;
    localparam int BASE_DIV = CLK_HZ / BASE_HZ;
    localparam logic [2:0] BASE_DIV_LAST = 3'(BASE_DIV - 1);
    localparam logic [2:0] RST_DIV       = 3'h0;

    typedef enum logic [1:0] {
        PTC_RW_LATCH,
        PTC_RW_LSB,
        PTC_RW_MSB,
        PTC_RW_BOTH
    } ptc_rw_t;

    typedef enum logic [2:0] {
        PTC_MODE0,
        PTC_MODE1,
        PTC_MODE2,
        PTC_MODE3,
        PTC_MODE4,
        PTC_MODE5
    } ptc_mode_t;

    // codes 6 and 7 alias the two periodic modes
    function automatic ptc_mode_t ptc_decode_mode(input logic [2:0] code);
        case (code)
            3'h0:    ptc_decode_mode = PTC_MODE0;
            3'h1:    ptc_decode_mode = PTC_MODE1;
            3'h2:    ptc_decode_mode = PTC_MODE2;
            3'h3:    ptc_decode_mode = PTC_MODE3;
            3'h4:    ptc_decode_mode = PTC_MODE4;
            3'h5:    ptc_decode_mode = PTC_MODE5;
            3'h6:    ptc_decode_mode = PTC_MODE2;
            default: ptc_decode_mode = PTC_MODE3;
        endcase
    endfunction : ptc_decode_mode

endpackage : ptc_pkg

// ### logic/ptc_top.sv
// pacer and pre-trigger counter block: host decode, cascade, pre-trigger gate
`timescale 1ns/1ps
`default_nettype none
module ptc_top
    import ptc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // host I/O access, address already relative to base
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // source selection from card configuration
    input  wire logic       ad_trig_sel_pacer,
    input  wire logic       second_interrupt_request_sel_ext,
    // connector pins
    input  wire logic       pretrig_in,
    input  wire logic       ext_trig_in,
    input  wire logic       ext_int_in,
    // outputs
    output logic            ad_trigger,
    output logic            pacer_out,
    output logic            second_interrupt_request,
    output logic            pretrig_gate
);

    logic [2:0] div;
    logic       base_tick;
    logic       stage2_tick;
    logic       out1_prev;
    logic [2:0] pre_sync;
    logic [2:0] trg_sync;
    logic [1:0] int_sync;
    logic       pre_fall;
    logic       ext_fall;
    logic       pacer_rise;
    logic [2:0] tick_v;
    logic [2:0] gate_v;
    logic [2:0] out_v;
    logic [2:0] tc_v;
    logic [2:0] wr_hit;
    logic [2:0] rd_hit;
    logic [2:0] ctl_hit;
    logic [7:0] rd_v [3];

    // one-hot counter data port select
    function automatic logic [2:0] port_hit(input logic [7:0] addr);
        port_hit = {addr == OFS_STAGE2, addr == OFS_STAGE1, addr == OFS_PRETRIG};
    endfunction : port_hit

    assign wr_hit = io_wr ? port_hit(io_addr) : 3'h0;
    assign rd_hit = io_rd ? port_hit(io_addr) : 3'h0;

    // 2 MHz base count tick from the system clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div       <= RST_DIV;
            base_tick <= 1'b0;
        end else begin
            base_tick <= (div == BASE_DIV_LAST);
            div       <= (div == BASE_DIV_LAST) ? RST_DIV : div + 3'h1;
        end
    end

    // pin synchronisers; the third stage only holds the previous level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_sync <= 3'h7;
            trg_sync <= 3'h7;
            int_sync <= 2'h0;
        end else begin
            pre_sync <= {pre_sync[1:0], pretrig_in};
            trg_sync <= {trg_sync[1:0], ext_trig_in};
            int_sync <= {int_sync[0], ext_int_in};
        end
    end

    assign pre_fall   = !pre_sync[1] && pre_sync[2];
    assign ext_fall   = !trg_sync[1] && trg_sync[2];
    assign pacer_rise = out_v[2] && !pacer_out;

    // stage one output edge clocks stage two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out1_prev   <= 1'b0;
            stage2_tick <= 1'b0;
        end else begin
            out1_prev   <= out_v[1];
            stage2_tick <= out_v[1] && !out1_prev;
        end
    end

    // trigger, pacer and interrupt routing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ad_trigger               <= 1'b0;
            pacer_out                <= 1'b0;
            second_interrupt_request <= 1'b0;
        end else begin
            ad_trigger               <= ad_trig_sel_pacer ? pacer_rise : ext_fall;
            pacer_out                <= out_v[2];
            second_interrupt_request <= second_interrupt_request_sel_ext ? int_sync[1] : out_v[2];
        end
    end

    // pre-trigger gate; a falling edge wins over the terminal count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pretrig_gate <= 1'b0;
        end else if (pre_fall) begin
            pretrig_gate <= 1'b1;
        end else if (tc_v[0]) begin
            pretrig_gate <= 1'b0;
        end
    end

    // read data; control location and unmapped addresses read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= RST_BYTE;
        end else if (io_rd) begin
            io_rdata <= rd_hit[0] ? rd_v[0] : rd_hit[1] ? rd_v[1] : rd_hit[2] ? rd_v[2] : RST_BYTE;
        end
    end

    // counter 0 counts A/D triggers, 1 divides the base clock, 2 divides counter 1
    assign tick_v = {stage2_tick, base_tick, ad_trigger};
    // the pacer stages run ungated; host sets them to mode 3
    assign gate_v = {1'b1, 1'b1, pretrig_gate};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            assign ctl_hit[gi] = io_wr && (io_addr == OFS_CONTROL)
                                 && (io_wdata[CTL_SEL_MSB:CTL_SEL_LSB] == 2'(gi));
            ptc_counter u_cnt (
                .clk     (clk),
                .nrst    (nrst),
                .ctl_wr  (ctl_hit[gi]),
                .data_wr (wr_hit[gi]),
                .data_rd (rd_hit[gi]),
                .wdata   (io_wdata),
                .rdata   (rd_v[gi]),
                .tick    (tick_v[gi]),
                .gate    (gate_v[gi]),
                .out     (out_v[gi]),
                .tc      (tc_v[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_tick_gap;
        !base_tick [*4] ##1 base_tick;
    endsequence

    // high for exactly one cycle
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence

    property p_base_tick_period;
        base_tick |=> s_tick_gap;
    endproperty
    a_base_tick_period: assert property (p_base_tick_period) else $error("base tick not every 5 clocks");

    property p_stage_two_clock;
        $rose(out_v[1]) |=> s_pulse(stage2_tick);
    endproperty
    a_stage_two_clock: assert property (p_stage_two_clock) else $error("stage two not clocked by stage one");

    property p_pacer_trigger;
        (pacer_rise && ad_trig_sel_pacer) |=> (ad_trigger && pacer_out);
    endproperty
    a_pacer_trigger: assert property (p_pacer_trigger) else $error("pacer edge gave no A/D trigger");

    property p_ext_trigger;
        (ext_fall && !ad_trig_sel_pacer) |=> s_pulse(ad_trigger);
    endproperty
    a_ext_trigger: assert property (p_ext_trigger) else $error("external edge gave no A/D trigger");

    property p_pacer_second_interrupt_request;
        (pacer_rise && !second_interrupt_request_sel_ext) |=> second_interrupt_request;
    endproperty
    a_pacer_second_interrupt_request: assert property (p_pacer_second_interrupt_request) else $error("pacer not routed to second interrupt");

    property p_gate_set;
        pre_fall |=> pretrig_gate;
    endproperty
    a_gate_set: assert property (p_gate_set) else $error("pre-trigger fall did not open gate");

    property p_gate_clear;
        (tc_v[0] && !pre_fall) |=> !pretrig_gate;
    endproperty
    a_gate_clear: assert property (p_gate_clear) else $error("gate not closed at zero");

    property p_unmapped_read;
        (io_rd && (port_hit(io_addr) == 3'h0)) |=> (io_rdata == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_ext_second_interrupt_request;
        second_interrupt_request_sel_ext |=> (second_interrupt_request == $past(int_sync[1]));
    endproperty
    a_ext_second_interrupt_request: assert property (p_ext_second_interrupt_request) else $error("external interrupt not routed");

    property p_rdata_hold;
        !io_rd |=> $stable(io_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

endmodule : ptc_top
`default_nettype wire

// ### tb/ptc_host.sv
// host bus model: byte-wide writes and reads on the card I/O space
`timescale 1ns/1ps
`default_nettype none
module ptc_host (
    // clock
    input  wire logic       clk,
    // host bus
    output logic      [7:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    initial begin
        io_addr  = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // one byte per access; a full count takes two calls, low byte first
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        io_addr  = addr;
        io_wdata = data;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr    = 1'b0;
        io_wdata = ~data;
    endtask : wr

    // read byte is registered on the taking edge and stands until the next read
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        io_addr = addr;
        io_rd   = 1'b1;
        @(negedge clk);
        io_rd   = 1'b0;
        data    = io_rdata;
    endtask : rd
endmodule : ptc_host
`default_nettype wire

// ### tb/ptc_top_tb.sv
// self-checking bench for the pacer and pre-trigger counter block
`timescale 1ns/1ps
`default_nettype none
module ptc_top_tb;
    import ptc_pkg::*;

    logic       clk;
    logic       nrst;
    logic [7:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       ad_trig_sel_pacer;
    logic       second_interrupt_request_sel_ext;
    logic       pretrig_in;
    logic       ext_trig_in;
    logic       ext_int_in;
    logic       ad_trigger;
    logic       pacer_out;
    logic       second_interrupt_request;
    logic       pretrig_gate;
    int         errors;
    int         check_count;
    int         cycles;
    int         n;
    int         i;
    int         hi;
    int         lo;
    logic [7:0] rb;

    ptc_top dut (
        .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .ad_trig_sel_pacer(ad_trig_sel_pacer),
        .second_interrupt_request_sel_ext(second_interrupt_request_sel_ext), .pretrig_in(pretrig_in), .ext_trig_in(ext_trig_in),
        .ext_int_in(ext_int_in), .ad_trigger(ad_trigger), .pacer_out(pacer_out),
        .second_interrupt_request(second_interrupt_request), .pretrig_gate(pretrig_gate)
    );

    ptc_host host (
        .clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // cycles that pacer_out keeps the given level, bounded
    task automatic measure(input logic lvl, output int c);
        c = 0;
        while (pacer_out === lvl && c < 400) begin
            @(negedge clk);
            c++;
        end
    endtask : measure

    task automatic count_trig(input int len, output int c);
        c = 0;
        repeat (len) begin
            @(negedge clk);
            if (ad_trigger === 1'b1) c++;
        end
    endtask : count_trig

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        errors = 0;
        check_count = 0;
        cycles = 0;
        nrst = 1'b0;
        ad_trig_sel_pacer = 1'b1;
        second_interrupt_request_sel_ext = 1'b0;
        pretrig_in = 1'b1;
        ext_trig_in = 1'b1;
        ext_int_in = 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        host.rd(OFS_PRETRIG, rb);
        check(16'(rb), 16'h0000);
        host.rd(OFS_CONTROL, rb);
        check(16'(rb), 16'h0000);
        host.rd(8'h48, rb);
        check(16'(rb), 16'h0000);
        // both pacer stages in square-wave mode, divisor 2 each
        host.wr(OFS_CONTROL, 8'h76);
        host.wr(OFS_STAGE1, 8'h02);
        host.wr(OFS_STAGE1, 8'h00);
        host.wr(OFS_CONTROL, 8'hb6);
        host.wr(OFS_STAGE2, 8'h02);
        host.wr(OFS_STAGE2, 8'h00);
        measure(1'b0, n);
        measure(1'b1, n);
        measure(1'b0, n);
        measure(1'b1, hi);
        measure(0, lo);
        check(16'(hi), 16'h000a);
        check(16'(hi + lo), 16'h0014);
        // one trigger pulse per pacer period, starting at a pacer rise
        count_trig(200, n);
        check(16'(n), 16'h000a);
        repeat (40) begin
            @(negedge clk);
            check(16'(second_interrupt_request), 16'(pacer_out));
        end
        second_interrupt_request_sel_ext = 1'b1;
        ext_int_in = 1'b1;
        repeat (6) @(negedge clk);
        check(16'(second_interrupt_request), 16'h0001);
        ext_int_in = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(second_interrupt_request), 16'h0000);
        // pre-trigger counter: event counting, count of 3 samples
        host.wr(OFS_CONTROL, 8'h10);
        host.wr(OFS_PRETRIG, 8'h03);
        repeat (45) @(negedge clk);
        host.wr(OFS_CONTROL, 8'h00);
        host.rd(OFS_PRETRIG, rb);
        check(16'(rb), 16'h0003);
        check(16'(pretrig_gate), 16'h0000);
        for (i = 0; i < 100 && ad_trigger !== 1'b1; i++) @(negedge clk);
        pretrig_in = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(pretrig_gate), 16'h0001);
        n = 0;
        for (i = 0; i < 200 && pretrig_gate === 1'b1; i++) begin
            if (ad_trigger === 1'b1) n++;
            @(negedge clk);
        end
        check(16'(n), 16'h0003);
        check(16'(pretrig_gate), 16'h0000);
        pretrig_in = 1'b1;
        // external trigger source replaces the pacer
        ad_trig_sel_pacer = 1'b0;
        repeat (5) @(negedge clk);
        count_trig(40, n);
        check(16'(n), 16'h0000);
        ext_trig_in = 1'b0;
        count_trig(10, n);
        check(16'(n), 16'h0001);
        ext_trig_in = 1'b1;
        // two-byte count read back latched, then a high-byte-only count; gate stays shut
        host.wr(OFS_CONTROL, 8'h30);
        host.wr(OFS_PRETRIG, 8'h34);
        host.wr(OFS_PRETRIG, 8'h12);
        ext_trig_in = 1'b0;
        repeat (6) @(negedge clk);
        ext_trig_in = 1'b1;
        host.wr(OFS_CONTROL, 8'h00);
        host.rd(OFS_PRETRIG, rb);
        check(16'(rb), 16'h0034);
        host.rd(OFS_PRETRIG, rb);
        check(16'(rb), 16'h0012);
        host.wr(OFS_CONTROL, 8'h20);
        host.wr(OFS_PRETRIG, 8'h56);
        ext_trig_in = 1'b0;
        repeat (6) @(negedge clk);
        ext_trig_in = 1'b1;
        host.rd(OFS_PRETRIG, rb);
        check(16'(rb), 16'h0056);
        summarize();
    end
endmodule : ptc_top_tb
`default_nettype wire
